// [design/timer8_core.sv]
/*
 * Eight-bit timer/counter core with two compare channels, a shared
 * free-running prescaler, external pin edge counting and a classic
 * Wishbone register slave. Assumes one clock, clk, an asynchronous
 * active-low reset and an external count pin from outside the domain.
 */
// The Wishbone register port and the register offsets are this design's own decisions.
// Notes on behaviour
// RL1 - Power-off bit set keeps timer disabled
// RL2 - Zero count raises bottom indication
// RL3 - All-ones count is the maximum
// RL4 - Top is maximum or compare A by mode
// RL5 - Count and compare registers are eight bits
// RL6 - Three request flags in one register
// RL7 - Each request gated by own mask bit
// RL8 - Clock select zero stops the counter
// RL9 - Clock select picks source and edge
// RL10 - Clock select field lives in control B
// RL11 - Both compares checked against count always
// RL12 - Compare match sets channel match flag
// RL13 - Match drives channel waveform output
// RL14 - Each tick clears, increments or decrements
// RL15 - Count readable and writable any time
// RL16 - Software count write beats counting
// RL17 - Mode field split across control A, B
// RL18 - Overflow flag set where mode says
// RL19 - Top and bottom indications provided
// RL20 - Select codes: direct, prescaled, pin edges
// RL21 - Flag set next tick; cleared ack/one
// RL22 - Count write blocks next tick's matches
// RL23 - Normal mode wraps, overflow at zero
// RL24 - Reset clears counts, flags, masks; stopped
`timescale 1ns/100ps

module timer8_core
	import timer8_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        external_count_pin,
	input  flags_t           irq_ack,
	output flags_t           irq_req,
	output logic             wave_out_a,
	output logic             wave_out_b,
	output logic             top_out,
	output logic             bottom_out
);

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [1:0]  wave_low_q;
	logic        wave_bit2_q;
	logic [2:0]  clk_sel_q;
	logic        power_off_q;
	logic [7:0]  count_value_q;
	logic [7:0]  count_value_d;
	logic [7:0]  cmp_buf_q [2];
	logic [7:0]  cmp_act_q [2];
	logic        match_flag_q [2];
	logic        match_now [2];
	logic        wave_q [2];
	logic        overflow_flag_q;
	flags_t      mask_q;
	flags_t      flags_rd;
	flags_t      irq_q;
	count_dir_t  dir_q;
	count_dir_t  dir_d;
	wave_mode_t  mode;
	logic [9:0]  pre_q;
	logic        pin_s1_q;
	logic        pin_s2_q;
	logic        pin_prev_q;
	logic        timer_tick;
	logic        block_q;
	logic        ovf_event;
	logic        at_top;
	logic        at_bottom;
	logic        update_point;
	logic        is_pwm;
	logic        is_phase;
	logic        top_is_a;
	logic [7:0]  top_val;
	logic        bus_req;
	logic        bus_wr;
	logic [4:0]  ofs;
	logic        ack_q;
	logic [31:0] rd_data_q;
	logic [31:0] rd_mux;
	logic        wr_low;
	logic        top_q;
	logic        bottom_q;

	// ************************************************************
	// Bus decode
	// ************************************************************
	// Only the low byte carries data, so writes need lane 0
	assign ofs     = wb_adr_i[4:0];
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign bus_wr  = bus_req & wb_we_i;
	assign wr_low  = bus_wr & wb_sel_i[0];

	// Acknowledge one cycle after the request, drop it the next
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ack_q <= 1'b0;
		else
			ack_q <= bus_req;
	end

	// Mode field assembled from both control registers
	assign mode = wave_mode_t'({wave_bit2_q, wave_low_q}); // see RL17

	// Read multiplexer; unmapped offsets read as zero
	always_comb
	begin
		rd_mux = UNMAPPED_READ;
		case (ofs)
			OFS_CONTROL_A: rd_mux[WAVE_LOW_LSB +: 2] = wave_low_q;
			OFS_CONTROL_B:
			begin
				rd_mux[CLK_SEL_LSB +: 3]  = clk_sel_q;
				rd_mux[WAVE_BIT2_POS]     = wave_bit2_q;
			end
			OFS_COUNT:     rd_mux[7:0] = count_value_q; // see RL15
			OFS_COMPARE_A: rd_mux[7:0] = cmp_buf_q[0];
			OFS_COMPARE_B: rd_mux[7:0] = cmp_buf_q[1];
			OFS_FLAGS:     rd_mux[2:0] = flags_rd; // see RL6
			OFS_MASK:      rd_mux[2:0] = mask_q;
			OFS_POWER:     rd_mux[POWER_OFF_POS] = power_off_q;
			default:       rd_mux = UNMAPPED_READ;
		endcase
	end

	// Read data captured with the acknowledge
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rd_data_q <= UNMAPPED_READ;
		else if (bus_req)
			rd_data_q <= rd_mux;
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rd_data_q;

	// ************************************************************
	// Control registers
	// ************************************************************
	// Mode, clock select and power bits
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wave_low_q  <= 2'h0;
			wave_bit2_q <= 1'b0;
			clk_sel_q   <= CLK_SEL_RESET; // see RL24
			power_off_q <= POWER_RESET;
		end
		else if (wr_low)
		begin
			case (ofs)
				OFS_CONTROL_A: wave_low_q <= wb_dat_i[WAVE_LOW_LSB +: 2];
				OFS_CONTROL_B:
				begin
					clk_sel_q   <= wb_dat_i[CLK_SEL_LSB +: 3]; // see RL10
					wave_bit2_q <= wb_dat_i[WAVE_BIT2_POS];
				end
				OFS_POWER: power_off_q <= wb_dat_i[POWER_OFF_POS];
				default: ;
			endcase
		end
	end

	// Interrupt mask register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mask_q <= '0; // see RL24
		else if (wr_low && ofs == OFS_MASK)
			mask_q <= flags_t'(wb_dat_i[2:0]);
	end

	// ************************************************************
	// Clock selection
	// ************************************************************
	// Free-running prescaler shared by all divided taps
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pre_q <= 10'h000;
		else
			pre_q <= pre_q + 10'h001;
	end

	// Pin synchroniser; the first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_q   <= 1'b0;
			pin_s2_q   <= 1'b0;
			pin_prev_q <= 1'b0;
		end
		else
		begin
			pin_s1_q   <= external_count_pin;
			pin_s2_q   <= pin_s1_q;
			pin_prev_q <= pin_s2_q;
		end
	end

	// Tick source and edge chosen by clock select
	always_comb
	begin
		case (clk_sel_q) // see RL9
			CS_STOP:     timer_tick = 1'b0; // see RL8
			CS_DIV1:     timer_tick = 1'b1; // see RL20
			CS_DIV8:     timer_tick = &pre_q[2:0];
			CS_DIV64:    timer_tick = &pre_q[5:0];
			CS_DIV256:   timer_tick = &pre_q[7:0];
			CS_DIV1024:  timer_tick = &pre_q[9:0];
			CS_EXT_FALL: timer_tick = pin_prev_q & ~pin_s2_q;
			CS_EXT_RISE: timer_tick = ~pin_prev_q & pin_s2_q;
			default:     timer_tick = 1'b0;
		endcase
		if (power_off_q)
			timer_tick = 1'b0; // see RL1
	end

	// ************************************************************
	// Counter unit
	// ************************************************************
	// Mode properties
	always_comb
	begin
		is_pwm   = 1'b0;
		is_phase = 1'b0;
		top_is_a = 1'b0;
		case (mode)
			WM_PHASE_MAX: {is_pwm, is_phase} = 2'h3;
			WM_FAST_MAX:  is_pwm = 1'b1;
			WM_CTC:       top_is_a = 1'b1;
			WM_PHASE_A:   {is_pwm, is_phase, top_is_a} = 3'h7;
			WM_FAST_A:    {is_pwm, top_is_a} = 2'h3;
			default:      is_pwm = 1'b0;
		endcase
	end

	// Top is fixed maximum or compare A
	assign top_val   = top_is_a ? cmp_act_q[0] : COUNT_MAX; // see RL4
	assign at_top    = (count_value_q == top_val);
	assign at_bottom = (count_value_q == COUNT_BOTTOM); // see RL2

	// Next count and direction for one tick
	always_comb
	begin
		count_value_d = count_value_q;
		dir_d         = dir_q;
		ovf_event     = 1'b0;
		if (timer_tick)
		begin
			if (is_phase)
			begin
				// Up to top, down to bottom; overflow at bottom
				ovf_event = at_bottom;
				if (dir_q == DIR_UP && at_top)
					dir_d = DIR_DOWN;
				else if (dir_q == DIR_DOWN && at_bottom)
					dir_d = DIR_UP;
				if (dir_d == DIR_UP)
					count_value_d = count_value_q + 8'h01; // see RL14
				else
					count_value_d = count_value_q - 8'h01;
			end
			else if (is_pwm || top_is_a)
			begin
				// Clear at top; overflow at max or fast top
				ovf_event = is_pwm ? at_top : (count_value_q == COUNT_MAX); // see RL18
				if (at_top)
					count_value_d = COUNT_BOTTOM;
				else
					count_value_d = count_value_q + 8'h01;
			end
			else
			begin
				// Normal: wrap past max, flag as count turns zero
				ovf_event     = (count_value_q == COUNT_MAX); // see RL23
				count_value_d = count_value_q + 8'h01;
			end
		end
		if (wr_low && ofs == OFS_COUNT)
			count_value_d = wb_dat_i[7:0]; // see RL16
	end

	// Count value and direction state
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_value_q <= COUNT_RESET; // see RL5
			dir_q         <= DIR_UP;
		end
		else
		begin
			count_value_q <= count_value_d;
			dir_q         <= is_phase ? dir_d : DIR_UP;
		end
	end

	// Count write blocks matches until the next tick passes
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			block_q <= 1'b0;
		else if (wr_low && ofs == OFS_COUNT)
			block_q <= 1'b1; // see RL22
		else if (timer_tick)
			block_q <= 1'b0;
	end

	// Buffers reload at top in PWM modes, at once otherwise
	assign update_point = timer_tick & at_top;

	// Top and bottom indications
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			top_q    <= 1'b0;
			bottom_q <= 1'b1;
		end
		else
		begin
			top_q    <= (count_value_d == top_val) | (count_value_d == COUNT_MAX); // see RL3
			bottom_q <= (count_value_d == COUNT_BOTTOM); // see RL19
		end
	end

	assign top_out    = top_q;
	assign bottom_out = bottom_q;

	// Overflow flag; a new event wins over a clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			overflow_flag_q <= 1'b0;
		else if (ovf_event)
			overflow_flag_q <= 1'b1;
		else if (irq_ack.overflow || (wr_low && ofs == OFS_FLAGS && wb_dat_i[FLAG_OVF_POS]))
			overflow_flag_q <= 1'b0;
	end

	// ************************************************************
	// Compare channels
	// ************************************************************
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			localparam logic [4:0] CH_OFS = (ch == 0) ? OFS_COMPARE_A : OFS_COMPARE_B;
			localparam int         CH_POS = (ch == 0) ? FLAG_A_POS : FLAG_B_POS;
			logic ch_ack;

			assign ch_ack = (ch == 0) ? irq_ack.match_a : irq_ack.match_b;

			// Comparator runs every cycle in every mode
			assign match_now[ch] = (count_value_q == cmp_act_q[ch]); // see RL11

			// Software side buffer of the compare value
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					cmp_buf_q[ch] <= COMPARE_RESET;
				else if (wr_low && ofs == CH_OFS)
					cmp_buf_q[ch] <= wb_dat_i[7:0];
			end

			// Active compare value seen by the comparator
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					cmp_act_q[ch] <= COMPARE_RESET;
				else if (!is_pwm || update_point)
					cmp_act_q[ch] <= cmp_buf_q[ch];
			end

			// Match flag set on the tick after the match
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					match_flag_q[ch] <= 1'b0;
				else if (timer_tick && match_now[ch] && !block_q)
					match_flag_q[ch] <= 1'b1; // see RL12
				else if (ch_ack || (wr_low && ofs == OFS_FLAGS && wb_dat_i[CH_POS]))
					match_flag_q[ch] <= 1'b0; // see RL21
			end

			// Waveform: toggle, fast PWM or phase correct PWM
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					wave_q[ch] <= 1'b0;
				else if (timer_tick)
				begin
					if (match_now[ch] && !block_q)
					begin
						if (!is_pwm)
							wave_q[ch] <= ~wave_q[ch]; // see RL13
						else if (is_phase)
							wave_q[ch] <= (dir_q == DIR_DOWN);
						else
							wave_q[ch] <= 1'b0;
					end
					else if (is_pwm && !is_phase && at_top)
						wave_q[ch] <= 1'b1;
				end
			end
		end
	endgenerate

	assign wave_out_a = wave_q[0];
	assign wave_out_b = wave_q[1];

	// ************************************************************
	// Request outputs
	// ************************************************************
	assign flags_rd.overflow = overflow_flag_q;
	assign flags_rd.match_a  = match_flag_q[0];
	assign flags_rd.match_b  = match_flag_q[1];

	// Each flag reaches its request only when unmasked
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_q <= '0;
		else
			irq_q <= flags_rd & mask_q; // see RL7
	end

	assign irq_req = irq_q;

endmodule

// [design/timer8_pkg.sv]
/*
 * Shared constants and types of the eight-bit timer/counter core.
 * Assumes a classic Wishbone slave with 32-bit data; each register
 * takes one aligned word and its data sits in the low byte.
 */
package timer8_pkg;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [4:0] OFS_CONTROL_A  = 5'h00;
	localparam logic [4:0] OFS_CONTROL_B  = 5'h04;
	localparam logic [4:0] OFS_COUNT      = 5'h08;
	localparam logic [4:0] OFS_COMPARE_A  = 5'h0C;
	localparam logic [4:0] OFS_COMPARE_B  = 5'h10;
	localparam logic [4:0] OFS_FLAGS      = 5'h14;
	localparam logic [4:0] OFS_MASK       = 5'h18;
	localparam logic [4:0] OFS_POWER      = 5'h1C;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int WAVE_LOW_LSB   = 0;
	localparam int CLK_SEL_LSB    = 0;
	localparam int WAVE_BIT2_POS  = 3;
	localparam int POWER_OFF_POS  = 0;
	localparam int FLAG_OVF_POS   = 0;
	localparam int FLAG_A_POS     = 1;
	localparam int FLAG_B_POS     = 2;

	// ************************************************************
	// Reset values and count limits
	// ************************************************************
	localparam logic [7:0] COUNT_RESET    = 8'h00;
	localparam logic [7:0] COMPARE_RESET  = 8'h00;
	localparam logic [2:0] CLK_SEL_RESET  = 3'h0;
	localparam logic       POWER_RESET    = 1'b0;
	localparam logic [7:0] COUNT_MAX      = 8'hFF;
	localparam logic [7:0] COUNT_BOTTOM   = 8'h00;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// ************************************************************
	// Clock select codes
	// ************************************************************
	localparam logic [2:0] CS_STOP     = 3'h0;
	localparam logic [2:0] CS_DIV1     = 3'h1;
	localparam logic [2:0] CS_DIV8     = 3'h2;
	localparam logic [2:0] CS_DIV64    = 3'h3;
	localparam logic [2:0] CS_DIV256   = 3'h4;
	localparam logic [2:0] CS_DIV1024  = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	// Waveform modes; 4 and 6 are reserved and run as normal mode
	typedef enum logic [2:0] {
		WM_NORMAL     = 3'b000,
		WM_PHASE_MAX  = 3'b001,
		WM_CTC        = 3'b010,
		WM_FAST_MAX   = 3'b011,
		WM_RSVD4      = 3'b100,
		WM_PHASE_A    = 3'b101,
		WM_RSVD6      = 3'b110,
		WM_FAST_A     = 3'b111
	} wave_mode_t;

	// Counting direction state
	typedef enum logic {
		DIR_UP   = 1'b0,
		DIR_DOWN = 1'b1
	} count_dir_t;

	// Three request flags in register bit order
	typedef struct packed {
		logic match_b;
		logic match_a;
		logic overflow;
	} flags_t;

endpackage

// [dv/timer8_core_chk.sv]
/* Port-level checker of timer8_core.
   Assumes one clock clk and the asynchronous active-low reset rst_n. */
`timescale 1ns/100ps

module timer8_core_chk
	import timer8_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        external_count_pin,
	input wire flags_t      irq_ack,
	input wire flags_t      irq_req,
	input wire logic        wave_out_a,
	input wire logic        wave_out_b,
	input wire logic        top_out,
	input wire logic        bottom_out
);
	// ****************
	// Bus handshake
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	ack_timing_a: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	ack_pulse_a: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	read_hold_a: assert property (
		!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
		else $error("read data moved while idle");
	byte_wide_a: assert property (
		wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("read data wider than a byte");

	// ****************
	// Counter indications
	// ****************
	reset_vals_a: assert property (
		$rose(rst_n) |-> bottom_out && !top_out && irq_req == 3'h0
			&& !wave_out_a && !wave_out_b)
		else $error("outputs wrong after reset");
	zero_bottom_a: assert property (
		wb_ack_o && $past(wb_we_i && wb_sel_i[0] && wb_adr_i[4:0] == OFS_COUNT
			&& wb_dat_i[7:0] == 8'h00) |-> ##[0:1] bottom_out)
		else $error("bottom missing after zero write");
	max_top_a: assert property (
		wb_ack_o && $past(wb_we_i && wb_sel_i[0] && wb_adr_i[4:0] == OFS_COUNT
			&& wb_dat_i[7:0] == 8'hFF) |-> ##[0:1] top_out)
		else $error("top missing after all-ones write");

	// Main scenarios reached
	cover property (wb_ack_o && !wb_we_i);
	cover property ($rose(irq_req.overflow));
	cover property ($rose(irq_req.match_b));
endmodule

bind timer8_core timer8_core_chk timer8_core_chk_i (.clk, .rst_n, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .external_count_pin,
	.irq_ack, .irq_req, .wave_out_a, .wave_out_b, .top_out, .bottom_out);

// [dv/timer8_core_tb.sv]
/* Self-checking bench of timer8_core.
   Drives the Wishbone slave, the count pin and irq_ack itself. */
`timescale 1ns/100ps

module timer8_core_tb
	import timer8_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [31:0] adr = 32'h0;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        pin = 1'b0;
	flags_t      iack = 3'h0;
	flags_t      irq;
	logic        top;
	logic        bot;
	logic        wave_a;
	logic        wave_b;
	int          bad_count = 0;
	int          n_tests = 0;

	// Clock of 5 ns period
	always #2.5 clk = ~clk;

	timer8_core timer8_core_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.external_count_pin(pin), .irq_ack(iack), .irq_req(irq),
		.wave_out_a(wave_a), .wave_out_b(wave_b), .top_out(top), .bottom_out(bot));

	// ****************
	// Shared tasks
	// ****************
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkf(input flags_t got, input flags_t exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t requests %b expected %b", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One classic cycle, held until ack is seen
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {27'h0, a};
		sel <= 4'hF;
		wdat <= {24'h0, d};
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t bus timeout", $time);
			wrap_up();
		end
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 8'h00, r);
		chk(r, e);
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset;
		for (int i = 0; i < 8; i++)
			rd(5'(i * 4), 32'h0);
		rd(5'h02, UNMAPPED_READ);
		chk({30'h0, bot, top}, 32'h2);
		chk({30'h0, wave_a, wave_b}, 32'h0);
		chkf(irq, 3'h0);
	endtask

	task automatic t_match;
		wr(OFS_COMPARE_A, 8'h03);
		wr(OFS_COMPARE_B, 8'h03);
		wr(OFS_MASK, 8'h06);
		wr(OFS_COUNT, 8'h03);
		tick(4);
		rd(OFS_FLAGS, 32'h0);
		rd(OFS_COUNT, 32'h3);
		wr(OFS_CONTROL_B, {5'h0, CS_DIV1});
		wr(OFS_CONTROL_B, 8'h00);
		rd(OFS_FLAGS, 32'h0);
		wr(OFS_COUNT, 8'h02);
		wr(OFS_CONTROL_B, {5'h0, CS_DIV1});
		wr(OFS_CONTROL_B, 8'h00);
		tick(2);
		chkf(irq, 3'b110);
		rd(OFS_FLAGS, 32'h6);
		chk({30'h0, wave_a, wave_b}, 32'h3);
		wr(OFS_FLAGS, 8'h04);
		rd(OFS_FLAGS, 32'h2);
		@(posedge clk) iack <= 3'b010;
		@(posedge clk) iack <= 3'b000;
		rd(OFS_FLAGS, 32'h0);
	endtask

	task automatic t_ovf;
		wr(OFS_COMPARE_A, 8'h80);
		wr(OFS_COMPARE_B, 8'h80);
		wr(OFS_MASK, 8'h01);
		wr(OFS_COUNT, 8'hFF);
		wr(OFS_COUNT, 8'hFD);
		wr(OFS_CONTROL_B, {5'h0, CS_DIV1});
		tick(4);
		wr(OFS_CONTROL_B, 8'h00);
		chkf(irq, 3'b001);
		rd(OFS_FLAGS, 32'h1);
		wr(OFS_MASK, 8'h00);
		tick(2);
		chkf(irq, 3'b000);
		wr(OFS_FLAGS, 8'h01);
		rd(OFS_FLAGS, 32'h0);
	endtask

	// Each internal rate runs for four of its periods
	task automatic t_rates;
		int          div [5] = '{1, 8, 64, 256, 1024};
		logic [31:0] r;
		for (int i = 0; i < 5; i++)
		begin
			wr(OFS_COUNT, 8'h00);
			wr(OFS_CONTROL_B, {5'h0, 3'(i + 1)});
			tick(4 * div[i]);
			wr(OFS_CONTROL_B, 8'h00);
			bus(1'b0, OFS_COUNT, 8'h00, r);
			chk({31'h0, r >= 4 && r <= 7}, 32'h1);
		end
	endtask

	// Three pin pulses, rising then falling edges
	task automatic t_ext;
		for (int e = 0; e < 2; e++)
		begin
			wr(OFS_COUNT, 8'h00);
			wr(OFS_CONTROL_B, {5'h0, e ? CS_EXT_FALL : CS_EXT_RISE});
			repeat (3)
			begin
				@(posedge clk) pin <= 1'b1;
				tick(4);
				@(posedge clk) pin <= 1'b0;
				tick(4);
			end
			tick(6);
			wr(OFS_CONTROL_B, 8'h00);
			rd(OFS_COUNT, 32'h3);
		end
	endtask

	task automatic t_power;
		wr(OFS_POWER, 8'h01);
		wr(OFS_COUNT, 8'h00);
		wr(OFS_CONTROL_B, {5'h0, CS_DIV1});
		tick(8);
		rd(OFS_COUNT, 32'h0);
		wr(OFS_CONTROL_B, 8'h00);
		wr(OFS_POWER, 8'h00);
	endtask

	// Modes whose top is compare A keep the count at or below it
	task automatic t_modes;
		logic [2:0]  m [3] = '{WM_CTC, WM_PHASE_A, WM_FAST_A};
		logic [31:0] r;
		wr(OFS_COMPARE_A, 8'h05);
		for (int i = 0; i < 3; i++)
		begin
			wr(OFS_CONTROL_A, {6'h0, m[i][1:0]});
			wr(OFS_COUNT, 8'h00);
			wr(OFS_CONTROL_B, {4'h0, m[i][2], CS_DIV1});
			tick(40);
			wr(OFS_CONTROL_B, {4'h0, m[i][2], CS_STOP});
			bus(1'b0, OFS_COUNT, 8'h00, r);
			chk({31'h0, r <= 5}, 32'h1);
			rd(OFS_CONTROL_B, {28'h0, m[i][2], 3'h0});
		end
		wr(OFS_CONTROL_A, 8'h00);
		wr(OFS_CONTROL_B, 8'h00);
	endtask

	// ****************
	// Main sequence
	// ****************
	initial
	begin
		tick(10);
		rst_n <= 1'b1;
		t_reset();
		t_match();
		t_ovf();
		t_rates();
		t_ext();
		t_power();
		t_modes();
		wr(OFS_CONTROL_B, {5'h0, CS_DIV1});
		tick(3);
		// Count writes while running must win over the tick
		wr(OFS_COUNT, 8'h00);
		chk({31'h0, bot}, 32'h1);
		wr(OFS_COUNT, 8'hFF);
		chk({31'h0, top}, 32'h1);
		@(posedge clk) rst_n <= 1'b0;
		tick(3);
		@(posedge clk) rst_n <= 1'b1;
		t_reset();
		wrap_up();
	end
endmodule
